//--- src/prs_pkg.sv
// package for the power resource sequencer
package prs_pkg;
    localparam int NRES = 8;
    localparam int TW   = 8;
    localparam int CW   = 4;
    // resource indices
    localparam int RES_CORE_BUCK_REGULATOR = 0;
    localparam int RES_CORE_LOW_DROPOUT_REGULATOR  = 1;
    localparam int RES_LOW_NOISE_LOW_DROPOUT_REGULATOR = 2;
    localparam int RES_XTAL  = 3;
    localparam int RES_PLL   = 4;
    localparam int RES_RADIO = 5;
    localparam int RES_CORE  = 6;
    localparam int RES_MISC  = 7;
    // register offsets
    localparam logic [7:0] OFF_MIN_MASK  = 8'h00;
    localparam logic [7:0] OFF_TIMER_REQ = 8'h04;
    localparam logic [7:0] OFF_STATUS    = 8'h08;
    localparam logic [7:0] OFF_PENDING   = 8'h0c;
    localparam logic [7:0] OFF_MODE      = 8'h10;
    localparam logic [7:0] OFF_CAL       = 8'h14;
    localparam logic [7:0] OFF_DLY_BASE  = 8'h40;
    localparam logic [7:0] OFF_DEP_BASE  = 8'h80;
    // reset values
    localparam logic [NRES-1:0] RST_MIN_MASK = 8'h07;
    localparam logic [TW-1:0]   RST_DELAY    = 8'h02;
    localparam logic [15:0]     RST_CAL_DIV  = 16'h02fb;
    // always-needed base set for core supplies
    localparam logic [NRES-1:0] CORE_SUPPLY_SET = 8'h07;
    // clock request to resource map, one set per request line
    localparam logic [NRES-1:0] CLK_MAP [CW] = '{8'h4f, 8'h5f, 8'h3f, 8'h47};
    typedef enum logic [1:0] {
        RS_DISABLED = 2'b00,
        RS_TRANS_ON = 2'b01,
        RS_ENABLED  = 2'b10,
        RS_TRANS_OFF= 2'b11
    } prs_state_type;
    typedef enum logic [2:0] {
        PM_OFF    = 3'b000,
        PM_ACTIVE = 3'b001,
        PM_DOZE   = 3'b010,
        PM_SAVE   = 3'b011,
        PM_DEEP   = 3'b100,
        PM_RESTORE= 3'b101
    } prs_mode_type;
endpackage

//--- src/prs_res_if.sv
// bundle between the sequencer core and one resource slice
`timescale 1ns/1ps
`default_nettype none
interface prs_res_if;
    logic                    tick;
    logic                    request;
    logic                    deps_ok;
    logic                    dependents_on;
    logic [prs_pkg::TW-1:0]  on_delay;
    logic [prs_pkg::TW-1:0]  off_delay;
    logic                    on_flag;
    logic                    trans_flag;
    prs_pkg::prs_state_type  state;
    modport slice (input tick, request, deps_ok, dependents_on, on_delay, off_delay,
                   output on_flag, trans_flag, state);
    modport core  (output tick, request, deps_ok, dependents_on, on_delay, off_delay,
                   input on_flag, trans_flag, state);
endinterface
`default_nettype wire

//--- src/prs_res_slice.sv
// one power resource: state flags and transition timer
`timescale 1ns/1ps
`default_nettype none
module prs_res_slice (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // link to core
    prs_res_if.slice  rif
);
    logic [prs_pkg::TW-1:0] timer_q;
    logic                   on_q;
    logic                   pend_q;
    logic                   start_on;
    logic                   start_off;

    assign start_on  = !on_q && !pend_q && rif.request && rif.deps_ok;
    assign start_off = on_q && !pend_q && !rif.request && !rif.dependents_on;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            timer_q <= '0;
            on_q    <= 1'b0;
            pend_q  <= 1'b0;
        end else if (ce && rif.tick) begin
            if (pend_q) begin
                timer_q <= timer_q - 1'b1;
                if (timer_q == 8'h01) begin
                    pend_q <= 1'b0;
                    on_q   <= !on_q;
                end
            end else if (start_on) begin
                if (rif.on_delay == '0) begin
                    on_q <= 1'b1;
                end else begin
                    timer_q <= rif.on_delay;
                    pend_q  <= 1'b1;
                end
            end else if (start_off) begin
                if (rif.off_delay == '0) begin
                    on_q <= 1'b0;
                end else begin
                    timer_q <= rif.off_delay;
                    pend_q  <= 1'b1;
                end
            end
        end
    end

    assign rif.on_flag    = on_q;
    assign rif.trans_flag = pend_q;
    always_comb begin
        case ({pend_q, on_q})
            2'b00:   rif.state = prs_pkg::RS_DISABLED;
            2'b01:   rif.state = prs_pkg::RS_ENABLED;
            2'b10:   rif.state = prs_pkg::RS_TRANS_ON;
            default: rif.state = prs_pkg::RS_TRANS_OFF;
        endcase
    end

    a_timer_zero_settled: assert property (@(posedge clk) disable iff (!resetn)
        (pend_q == (timer_q != '0))) else $error("timer nonzero while settled");
    a_expiry_flips_on: assert property (@(posedge clk) disable iff (!resetn)
        (ce && rif.tick && pend_q && timer_q == 8'h01) |=> (on_q != $past(on_q) && !pend_q))
        else $error("expiry did not flip state");
    a_tick_decrements: assert property (@(posedge clk) disable iff (!resetn)
        (ce && rif.tick && timer_q > 8'h01) |=> (timer_q == $past(timer_q) - 8'h01))
        else $error("timer did not decrement");
    a_no_tick_hold: assert property (@(posedge clk) disable iff (!resetn)
        !(ce && rif.tick) |=> $stable(timer_q) && $stable(on_q))
        else $error("state moved without tick");
endmodule
`default_nettype wire

//--- src/prs_sequencer.sv
// power resource sequencer top with mode control and register port
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each resource in one of four states
// - timer zero when settled, nonzero transitioning
// - load enable or disable delay on decision
// - decrement nonzero timers each low-power tick
// - expiry completes transition to enabled/disabled
// - zero delay switches resource immediately
// - expiry clears transition flag, inverts on flag
// - request from clocks, minimum mask, timers
// - map clock requests to resource sets
// - recompute required set every tick
// - compare required set against status
// - disable unrequested resource without powered dependents
// - enable requested resource with dependencies on
// - regulators all off only on pin low
// - core supplies on when resets deasserted
// - doze stops oscillator, keeps low-power clock
// - save core state before deep sleep
// - restore core state on wake
// - shutdown tristates outputs, gates inputs
// - power-up after shutdown keeps no state
// - calibrate sequencer timer against crystal clock
// - pin high enables, low holds reset
module prs_sequencer (
    // clock, reset, enable
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       ce,
    // host pin and low-power clock (sampled)
    input  wire logic                       wlan_power_enable_pin,
    input  wire logic                       low_power_clock,
    // requests and wake events
    input  wire logic [prs_pkg::CW-1:0]     clk_req,
    input  wire logic                       doze_req,
    input  wire logic                       deep_sleep_req,
    input  wire logic                       wake_ext_irq,
    input  wire logic                       wake_host_resume,
    input  wire logic                       xtal_ref_tick,
    // register port
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // power and control outputs
    output logic      [prs_pkg::NRES-1:0]   resource_enable,
    output logic                            wlan_reset_n,
    output logic                            osc_enable,
    output logic                            retention_save,
    output logic                            retention_restore,
    output logic                            io_oe_n,
    output logic                            input_enable
);
    logic [prs_pkg::NRES-1:0] min_mask_q;
    logic [prs_pkg::NRES-1:0] timer_req_q;
    logic [prs_pkg::NRES-1:0] dep_q [prs_pkg::NRES];
    logic [prs_pkg::TW-1:0]   on_dly_q [prs_pkg::NRES];
    logic [prs_pkg::TW-1:0]   off_dly_q [prs_pkg::NRES];
    logic [15:0]              cal_div_q;
    logic [15:0]              cal_cnt_q;
    logic                     lpo_q;
    logic                     tick;
    logic                     cal_tick;
    logic [prs_pkg::NRES-1:0] on_vec;
    logic [prs_pkg::NRES-1:0] pend_vec;
    logic [prs_pkg::NRES-1:0] req_set;
    logic [prs_pkg::NRES-1:0] clk_set;
    logic [prs_pkg::NRES-1:0] reg_off;
    prs_pkg::prs_mode_type    mode_q;
    logic [1:0]               state_vec [prs_pkg::NRES];

    prs_res_if rif [prs_pkg::NRES] ();

    // low-power clock edge gives the sequencer tick
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lpo_q <= 1'b0;
        end else if (ce) begin
            lpo_q <= low_power_clock;
        end
    end
    // calibrated extra tick from crystal reference, ORed with the low-power clock tick whenever the divider is nonzero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cal_cnt_q <= '0;
        end else if (ce && xtal_ref_tick) begin
            if (cal_cnt_q >= cal_div_q) begin
                cal_cnt_q <= '0;
            end else begin
                cal_cnt_q <= cal_cnt_q + 16'h0001;
            end
        end
    end
    assign cal_tick = xtal_ref_tick && (cal_cnt_q >= cal_div_q) && (cal_div_q != '0);
    assign tick = (low_power_clock && !lpo_q) || cal_tick;

    // requested set: clocks, minimum mask, request timers
    always_comb begin
        clk_set = '0;
        for (int i = 0; i < prs_pkg::CW; i++) begin
            if (clk_req[i] && mode_q == prs_pkg::PM_ACTIVE) begin
                clk_set = clk_set | prs_pkg::CLK_MAP[i];
            end
        end
    end
    always_comb begin
        // pin low forces every resource down; otherwise core supplies stay up
        if (!wlan_power_enable_pin) begin
            req_set = '0;
        end else begin
            req_set = clk_set | min_mask_q | timer_req_q | prs_pkg::CORE_SUPPLY_SET;
            if (mode_q == prs_pkg::PM_DOZE || mode_q == prs_pkg::PM_DEEP) begin
                req_set[prs_pkg::RES_XTAL] = 1'b0;
                req_set[prs_pkg::RES_PLL]  = 1'b0;
            end
            if (mode_q == prs_pkg::PM_DEEP) begin
                req_set[prs_pkg::RES_CORE] = 1'b0;
            end
            // restore waits for the core resource, so it must be asked for here
            if (mode_q == prs_pkg::PM_RESTORE) begin
                req_set[prs_pkg::RES_CORE] = 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < prs_pkg::NRES; g++) begin : gen_res
            logic [prs_pkg::NRES-1:0] dependents;
            for (genvar k = 0; k < prs_pkg::NRES; k++) begin : gen_dep
                assign dependents[k] = dep_q[k][g] && on_vec[k];
            end
            assign rif[g].tick          = tick;
            assign rif[g].request       = req_set[g];
            assign rif[g].deps_ok       = (dep_q[g] & ~on_vec) == '0;
            assign rif[g].dependents_on = |dependents;
            assign rif[g].on_delay      = on_dly_q[g];
            assign rif[g].off_delay     = off_dly_q[g];
            assign on_vec[g]            = rif[g].on_flag;
            assign pend_vec[g]          = rif[g].trans_flag;
            assign state_vec[g]         = rif[g].state;
            prs_res_slice u_slice (
                .clk    (clk),
                .resetn (resetn),
                .ce     (ce),
                .rif    (rif[g])
            );
        end
    endgenerate

    // power mode sequencing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_q <= prs_pkg::PM_OFF;
        end else if (ce) begin
            case (mode_q)
                prs_pkg::PM_OFF: begin
                    if (wlan_power_enable_pin) begin
                        mode_q <= prs_pkg::PM_ACTIVE;
                    end
                end
                prs_pkg::PM_ACTIVE: begin
                    if (!wlan_power_enable_pin) begin
                        mode_q <= prs_pkg::PM_OFF;
                    end else if (deep_sleep_req) begin
                        mode_q <= prs_pkg::PM_SAVE;
                    end else if (doze_req) begin
                        mode_q <= prs_pkg::PM_DOZE;
                    end
                end
                prs_pkg::PM_DOZE: begin
                    if (!wlan_power_enable_pin) begin
                        mode_q <= prs_pkg::PM_OFF;
                    end else if (!doze_req || wake_ext_irq || wake_host_resume || timer_req_q != '0) begin
                        mode_q <= prs_pkg::PM_ACTIVE;
                    end
                end
                prs_pkg::PM_SAVE: begin
                    mode_q <= prs_pkg::PM_DEEP;
                end
                prs_pkg::PM_DEEP: begin
                    if (!wlan_power_enable_pin) begin
                        mode_q <= prs_pkg::PM_OFF;
                    end else if (wake_ext_irq || wake_host_resume || timer_req_q != '0) begin
                        mode_q <= prs_pkg::PM_RESTORE;
                    end
                end
                prs_pkg::PM_RESTORE: begin
                    if (on_vec[prs_pkg::RES_CORE]) begin
                        mode_q <= prs_pkg::PM_ACTIVE;
                    end
                end
                default: mode_q <= prs_pkg::PM_OFF;
            endcase
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (!resetn || (ce && mode_q == prs_pkg::PM_OFF && !wlan_power_enable_pin)) begin
            min_mask_q  <= prs_pkg::RST_MIN_MASK;
            timer_req_q <= '0;
            cal_div_q   <= prs_pkg::RST_CAL_DIV;
            for (int i = 0; i < prs_pkg::NRES; i++) begin
                on_dly_q[i]  <= prs_pkg::RST_DELAY;
                off_dly_q[i] <= prs_pkg::RST_DELAY;
                dep_q[i]     <= (i > prs_pkg::RES_LOW_NOISE_LOW_DROPOUT_REGULATOR) ? 8'h01 : 8'h00;
            end
        end else if (ce && reg_wr) begin
            case (reg_addr)
                prs_pkg::OFF_MIN_MASK:  min_mask_q  <= reg_wdata[prs_pkg::NRES-1:0];
                prs_pkg::OFF_TIMER_REQ: timer_req_q <= reg_wdata[prs_pkg::NRES-1:0];
                prs_pkg::OFF_CAL:       cal_div_q   <= reg_wdata[15:0];
                default: begin
                    for (int i = 0; i < prs_pkg::NRES; i++) begin
                        if (reg_addr == prs_pkg::OFF_DLY_BASE + 8'(4 * i)) begin
                            on_dly_q[i]  <= reg_wdata[7:0];
                            off_dly_q[i] <= reg_wdata[15:8];
                        end
                        if (reg_addr == prs_pkg::OFF_DEP_BASE + 8'(4 * i)) begin
                            dep_q[i] <= reg_wdata[prs_pkg::NRES-1:0];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (ce) begin
            reg_rdata <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    prs_pkg::OFF_MIN_MASK:  reg_rdata <= {24'h0, min_mask_q};
                    prs_pkg::OFF_TIMER_REQ: reg_rdata <= {24'h0, timer_req_q};
                    prs_pkg::OFF_STATUS:    reg_rdata <= {24'h0, on_vec};
                    prs_pkg::OFF_PENDING:   reg_rdata <= {24'h0, pend_vec};
                    prs_pkg::OFF_MODE:      reg_rdata <= {29'h0, mode_q};
                    prs_pkg::OFF_CAL:       reg_rdata <= {16'h0, cal_div_q};
                    default: begin
                        for (int i = 0; i < prs_pkg::NRES; i++) begin
                            if (reg_addr == prs_pkg::OFF_DLY_BASE + 8'(4 * i)) begin
                                reg_rdata <= {16'h0, off_dly_q[i], on_dly_q[i]};
                            end
                            if (reg_addr == prs_pkg::OFF_DEP_BASE + 8'(4 * i)) begin
                                reg_rdata <= {22'h0, state_vec[i], dep_q[i]};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // outputs
    assign reg_off = '0;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            resource_enable   <= '0;
            wlan_reset_n      <= 1'b0;
            osc_enable        <= 1'b0;
            retention_save    <= 1'b0;
            retention_restore <= 1'b0;
            io_oe_n           <= 1'b1;
            input_enable      <= 1'b0;
        end else if (ce) begin
            resource_enable   <= wlan_power_enable_pin ? on_vec : reg_off;
            wlan_reset_n      <= wlan_power_enable_pin && mode_q != prs_pkg::PM_OFF;
            osc_enable        <= on_vec[prs_pkg::RES_XTAL]
                                 && mode_q != prs_pkg::PM_DOZE;
            retention_save    <= mode_q == prs_pkg::PM_SAVE;
            retention_restore <= mode_q == prs_pkg::PM_RESTORE;
            io_oe_n           <= mode_q == prs_pkg::PM_OFF;
            input_enable      <= mode_q != prs_pkg::PM_OFF;
        end
    end

    a_pin_low_off: assert property (@(posedge clk) disable iff (!resetn)
        (ce && !wlan_power_enable_pin) |=> (resource_enable == '0 && !wlan_reset_n))
        else $error("regulators on with pin low");
    a_save_before_deep: assert property (@(posedge clk) disable iff (!resetn)
        (ce && mode_q == prs_pkg::PM_DEEP && $past(mode_q) != prs_pkg::PM_DEEP)
        |-> $past(mode_q) == prs_pkg::PM_SAVE) else $error("deep sleep without save");
    a_doze_osc_off: assert property (@(posedge clk) disable iff (!resetn)
        (ce && mode_q == prs_pkg::PM_DOZE) |=> !osc_enable)
        else $error("oscillator running in doze");
    a_shutdown_tristate: assert property (@(posedge clk) disable iff (!resetn)
        (ce && mode_q == prs_pkg::PM_OFF) |=> (io_oe_n && !input_enable))
        else $error("outputs driven in shutdown");
endmodule
`default_nettype wire

//--- dv/prs_host_model.sv
// host side model that drives the power-enable pin
`timescale 1ns/1ps
`default_nettype none
module prs_host_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // bench command
    input  wire logic power_on,
    // pin toward the device
    output var logic  wlan_power_enable_pin = 1'b0
);
    // the pin moves only just after an edge, like a real host gpio
    always @(posedge clk) begin
        wlan_power_enable_pin <= resetn & power_on;
    end
endmodule
`default_nettype wire

//--- dv/pmu_resource_sequencer_bench.sv
// self-checking bench for the power resource sequencer
`timescale 1ns/1ps
`default_nettype none
module pmu_resource_sequencer_bench;
    logic                     clk = 1'b0;
    logic                     resetn = 1'b0;
    logic                     host_on = 1'b0;
    logic                     pin;
    logic                     lpc = 1'b0;
    logic [prs_pkg::CW-1:0]   clk_req = '0;
    logic                     doze_req = 1'b0;
    logic                     deep_req = 1'b0;
    logic                     wake = 1'b0;
    logic                     ret_s, ret_r;
    logic [7:0]               reg_addr = 8'h00;
    logic [31:0]              reg_wdata = 32'h0;
    logic                     reg_wr = 1'b0;
    logic                     reg_rd = 1'b0;
    logic [31:0]              reg_rdata;
    logic [prs_pkg::NRES-1:0] res_en;
    logic                     rst_n_out, osc_en, oe_n, in_en;
    int                       fails = 0;
    int                       checked = 0;
    always #20 clk = ~clk;
    prs_host_model i_prs_host_model (.clk(clk), .resetn(resetn), .power_on(host_on),
        .wlan_power_enable_pin(pin));
    // crystal calibration input stays quiet here
    prs_sequencer i_prs_sequencer (.clk(clk), .resetn(resetn), .ce(1'b1),
        .wlan_power_enable_pin(pin), .low_power_clock(lpc), .clk_req(clk_req),
        .doze_req(doze_req), .deep_sleep_req(deep_req), .wake_ext_irq(wake),
        .wake_host_resume(1'b0), .xtal_ref_tick(1'b0), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .resource_enable(res_en), .wlan_reset_n(rst_n_out), .osc_enable(osc_en),
        .retention_save(ret_s), .retention_restore(ret_r), .io_oe_n(oe_n),
        .input_enable(in_en));
    task automatic give_verdict();
        $display("fails %0d checked %0d", fails, checked);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp, what);
    endtask
    // a tick is one rising edge of the sampled low-power clock
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            lpc <= 1'b1;
            repeat (4) @(posedge clk);
            lpc <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    // bounded wait: at most 8 ticks for the on flags to settle
    task automatic settle(input logic [7:0] exp);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            if (res_en === exp) begin
                rdc(prs_pkg::OFF_STATUS, {24'h0, exp}, "status");
                return;
            end
            tick(1);
        end
        fails++;
        $display("[FAIL] %0t enables never reached %h", $time, exp);
        give_verdict();
    endtask
    task automatic sc_reset();
        chk(res_en, 0, "enables after reset");
        chk(rst_n_out, 0, "wireless reset");
        chk(oe_n, 1, "outputs tristated");
        chk(in_en, 0, "inputs gated");
    endtask
    task automatic sc_power_up();
        host_on <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(prs_pkg::OFF_MIN_MASK, 32'h07, "min mask");
        rdc(prs_pkg::OFF_CAL, 32'h2fb, "cal divider");
        rdc(prs_pkg::OFF_DLY_BASE, 32'h0202, "delay");
        rdc(8'h30, 32'h0, "unmapped");
        tick(1);
        rdc(prs_pkg::OFF_PENDING, 32'h07, "pending after load");
        rdc(prs_pkg::OFF_STATUS, 32'h00, "still off while timed");
        settle(8'h07);
        rdc(prs_pkg::OFF_PENDING, 32'h0, "pending cleared");
        chk(rst_n_out, 1, "wireless out of reset");
    endtask
    task automatic sc_zero_delay();
        wr(prs_pkg::OFF_DLY_BASE + 8'h0c, 32'h0);
        wr(prs_pkg::OFF_MIN_MASK, 32'h0f);
        tick(1);
        rdc(prs_pkg::OFF_STATUS, 32'h0f, "immediate on");
        rdc(prs_pkg::OFF_PENDING, 32'h0, "no pending");
        wr(prs_pkg::OFF_MIN_MASK, 32'h07);
        tick(1);
        rdc(prs_pkg::OFF_STATUS, 32'h07, "immediate off");
    endtask
    task automatic sc_clock_req();
        @(posedge clk);
        clk_req <= 4'h1;
        tick(1);
        rdc(prs_pkg::OFF_PENDING, 32'h40, "clock map load");
        settle(8'h4f);
        @(posedge clk);
        clk_req <= 4'h0;
        tick(1);
        rdc(prs_pkg::OFF_PENDING, 32'h40, "timed disable");
        settle(8'h07);
    endtask
    task automatic sc_doze();
        // the oscillator resource must be up first, else doze proves nothing
        @(posedge clk);
        clk_req <= 4'h1;
        settle(8'h4f);
        #1 chk(osc_en, 1, "oscillator running");
        doze_req <= 1'b1;
        tick(3);
        #1 chk(osc_en, 0, "oscillator stopped in doze");
        doze_req <= 1'b0;
        wr(prs_pkg::OFF_TIMER_REQ, 32'h01);
        tick(3);
        #1 chk(osc_en, 1, "oscillator back after wake");
        clk_req <= 4'h0;
        wr(prs_pkg::OFF_TIMER_REQ, 32'h0);
        settle(8'h07);
    endtask
    task automatic sc_deep();
        @(posedge clk);
        deep_req <= 1'b1;
        @(posedge clk);
        deep_req <= 1'b0;
        @(posedge clk);
        #1 chk(ret_s, 1, "state saved on entry");
        rdc(prs_pkg::OFF_MODE, 32'h04, "in deep sleep");
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        @(posedge clk);
        #1 chk(ret_r, 1, "state restored on wake");
        tick(4);
        rdc(prs_pkg::OFF_MODE, 32'h01, "back to active");
    endtask
    task automatic sc_power_down();
        @(posedge clk);
        host_on <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk(res_en, 0, "all off on pin low");
        chk(rst_n_out, 0, "wireless held in reset");
        host_on <= 1'b1;
        repeat (4) @(posedge clk);
        rdc(prs_pkg::OFF_DLY_BASE + 8'h0c, 32'h0202, "no state kept");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1 sc_reset();
        sc_power_up();
        sc_zero_delay();
        sc_clock_req();
        sc_doze();
        sc_deep();
        sc_power_down();
        give_verdict();
    end
endmodule
`default_nettype wire
